/* File: dv/rx_buffer_chain_and_completion_tb.sv */
// Self-checking bench for the buffer chain engine
`timescale 1ns/1ps
`default_nettype none
module rx_buffer_chain_and_completion_tb;
  logic                clk_sys, nrst, avs_read, avs_write, cmdValid, cmdReady;
  logic                doneValid, doneStarve, avs_waitrequest, memAck, compIrq;
  logic [5:0]          avs_address;
  logic [31:0]         avs_writedata, avs_readdata, memRdata, d;
  logic [3:0]          avs_byteenable;
  logic [1:0]          lat;
  rxbc_pkg::rxbc_cmd_s cm, cmdIn;
  rxbc_pkg::rxbc_mem_s memReq;
  int                  err_total, compares, irqs;
  rxbc_engine dut_u (.*);
  rxbc_mem_model mem_u (.*);
  // Clock and interrupt pulse count
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (compIrq === 1'b1) irqs++;
  function automatic logic [31:0] m(input logic [31:0] a);
    return mem_u.mem[a[10:2]];
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic cmd(input logic op, input logic st);
    cm.op = rxbc_pkg::rxbc_op_e'(op);
    @(posedge clk_sys);
    cmdIn <= cm;
    cmdValid <= 1'b1;
    do @(posedge clk_sys); while (cmdReady !== 1'b1);
    cmdValid <= 1'b0;
    do @(posedge clk_sys); while (doneValid !== 1'b1);
    chk({31'h0, doneStarve}, {31'h0, st});
  endtask
  task automatic cq(input logic [31:0] b, w0, w1);
    chk(m(b), w0);
    chk(m(b + 32'h4), w1);
  endtask
  task finish_test;
    $display("mismatches %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    finish_test();
  end
  // Main sequence
  initial begin
    {clk_sys, nrst, avs_read, avs_write, cmdValid} = 5'h00;
    {avs_address, avs_writedata, avs_byteenable, lat} = '0;
    {err_total, compares, irqs} = '0;
    cm = '0;
    cmdIn = '0;
    for (int i = 0; i < 512; i++) mem_u.mem[i] = 32'(i * 4) ^ 32'h5A5A0000;
    // Buffers 128 bytes apart, word aligned; entry 3 not handed over
    mem_u.mem[32'h40] = 32'h80000100;
    mem_u.mem[32'h41] = 32'h80000120;
    mem_u.mem[32'h42] = 32'h80000140;
    mem_u.mem[32'h43] = 32'h00000160;
    mem_u.mem[32'h60] = 32'h80000161;
    avs_byteenable = 4'hF;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    acc(1'b0, rxbc_pkg::REG_CTRL, 32'h0);
    chk(d, {30'h0, rxbc_pkg::CTRL_RST});
    acc(1'b0, rxbc_pkg::REG_CQ0_BASE, 32'h0);
    chk(d, rxbc_pkg::BASE_RST);
    acc(1'b1, 6'h3C, 32'hFFFFFFFF);
    acc(1'b0, 6'h3C, 32'h0);
    chk(d, 32'h00000000);
    acc(1'b1, rxbc_pkg::REG_FREE_BASE, 32'h100);
    acc(1'b1, rxbc_pkg::REG_FREE_SIZE, 32'h3);
    acc(1'b1, rxbc_pkg::REG_CQ0_BASE, 32'h200);
    acc(1'b1, rxbc_pkg::REG_CQ0_SIZE, 32'h1);
    acc(1'b1, rxbc_pkg::REG_CQ1_BASE, 32'h300);
    acc(1'b1, rxbc_pkg::REG_CQ1_SIZE, 32'h1);
    // Two-buffer AAL5 packet with overflow, CRC and abort flags, interrupt ring
    cm.header = 32'h12345678;
    {cm.aal5, cm.cellCount, cm.crcCalc, cm.efciCount} = {1'b1, 11'h557, 32'h1, 10'h155};
    cmd(1'b0, 1'b0);
    cmd(1'b0, 1'b0);
    cmd(1'b1, 1'b0);
    chk(m(32'h100), 32'h00000100);
    chk(m(32'h104), 32'h00000120);
    chk(m(32'h404), 32'h80000120);
    chk(m(32'h484), 32'h40000000);
    chk(m(32'h408), 32'h12345678);
    chk(m(32'h400) ^ m(32'h40C), 32'h0000000C);
    cq(32'h200, 32'h12345678, 32'hCC000155);
    chk(m(32'h208), 32'h80000100);
    chk(irqs, 1);
    // Aged-out packet on the polled ring with slow memory
    lat <= 2'h3;
    cm = '0;
    {cm.ringSel, cm.timeout, cm.vpiVci} = {2'h3, 28'hABCDEF1};
    cmd(1'b0, 1'b0);
    cmd(1'b1, 1'b0);
    chk(m(32'h504), 32'hC0000000);
    cq(32'h300, 32'hABCDEF10, 32'h10000000);
    chk(irqs, 1);
    acc(1'b0, rxbc_pkg::REG_CQ_IDX, 32'h0);
    chk(d, 32'h00010001);
    // Starvation: entry not handed over, then starved close
    lat <= 2'h1;
    {cm.ringSel, cm.timeout} = 2'h0;
    cmd(1'b0, 1'b1);
    chk(m(32'h10C), 32'h00000160);
    cmd(1'b1, 1'b1);
    chk(m(32'h224), 32'h20000000);
    chk(m(32'h228) & 32'h80000000, 32'h0);
    chk(irqs, 2);
    // FIFO mode, 64-bit bus, misaligned buffer address
    acc(1'b1, rxbc_pkg::REG_CTRL, 32'h3);
    acc(1'b1, rxbc_pkg::REG_FREE_BASE, 32'h180);
    cm.ringSel = 1'b1;
    cmd(1'b0, 1'b0);
    chk(m(32'h180), 32'h80000161);
    acc(1'b0, rxbc_pkg::REG_STATUS, 32'h0);
    chk(d & 32'h20000000, 32'h20000000);
    acc(1'b1, rxbc_pkg::REG_STATUS, 32'h20000000);
    acc(1'b0, rxbc_pkg::REG_STATUS, 32'h0);
    chk(d & 32'h20000000, 32'h0);
    // Second FIFO buffer links the current one; entry still never written
    cmd(1'b0, 1'b0);
    chk(m(32'h588), 32'h80000161);
    chk(m(32'h180), 32'h80000161);
    cmd(1'b1, 1'b0);
    chk(m(32'h588), 32'h40000000);
    acc(1'b0, rxbc_pkg::REG_CQ_IDX, 32'h0);
    chk(d, 32'h00000000);
    finish_test();
  end
endmodule
`default_nettype wire

/* File: dv/rxbc_engine_properties.sv */
// Port-level checks for the buffer chain engine
`timescale 1ns/1ps
`default_nettype none
module rxbc_engine_properties (
  input wire logic                clk_sys,
  input wire logic                nrst,
  input wire logic [5:0]          avs_address,
  input wire logic                avs_read,
  input wire logic                avs_write,
  input wire logic [31:0]         avs_writedata,
  input wire logic [3:0]          avs_byteenable,
  input wire logic                avs_waitrequest,
  input wire logic                cmdValid,
  input wire rxbc_pkg::rxbc_cmd_s cmdIn,
  input wire logic                cmdReady,
  input wire logic                doneValid,
  input wire logic                doneStarve,
  input wire rxbc_pkg::rxbc_mem_s memReq,
  input wire logic                memAck,
  input wire logic [31:0]         memRdata,
  input wire logic                compIrq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic        op_q, ring_q, fifo_q, first_q, irq_q;
  logic [31:0] ent_q, entA_q;
  // Track mode, current command and the first answer after a take
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      {op_q, ring_q, fifo_q, first_q, irq_q} <= 5'h00;
      ent_q <= 32'h00000000;
      entA_q <= 32'h00000000;
    end else begin
      if (avs_write && !avs_waitrequest && avs_address == rxbc_pkg::REG_CTRL
          && avs_byteenable[0])
        fifo_q <= avs_writedata[0];
      if (cmdValid && cmdReady) begin
        op_q <= cmdIn.op;
        ring_q <= cmdIn.ringSel;
        first_q <= 1'b1;
        irq_q <= 1'b0;
      end else if (memAck && first_q) begin
        first_q <= 1'b0;
        ent_q <= memRdata;
        entA_q <= memReq.addr;
      end
      if (compIrq)
        irq_q <= 1'b1;
    end
  end
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=>
    !avs_waitrequest ##1 avs_waitrequest) else $error("register access not one cycle");
  a_mem_hold: assert property (
    memReq.valid && !memAck |=> memReq.valid && $stable(memReq))
    else $error("memory request changed before ack");
  a_ack_drop: assert property (memAck |=> !memReq.valid)
    else $error("memory request kept after ack");
  a_own_take: assert property (doneValid && op_q == rxbc_pkg::RXBC_OP_NEWBUF |->
    doneStarve == !ent_q[31]) else $error("starve flag disagrees with entry");
  a_ring_return: assert property (memReq.valid && memReq.write && !first_q
    && op_q == rxbc_pkg::RXBC_OP_NEWBUF && memReq.addr == entA_q |-> ent_q[31]
    && memReq.wdata == {1'b0, ent_q[30:0]}) else $error("bad entry write-back");
  a_fifo_nowrite: assert property (memReq.valid && memReq.write && fifo_q
    && op_q == rxbc_pkg::RXBC_OP_NEWBUF |-> memReq.addr != entA_q)
    else $error("fifo entry written");
  a_irq_ring: assert property (compIrq |-> op_q == rxbc_pkg::RXBC_OP_CLOSE
    && ring_q == rxbc_pkg::IRQ_RING) else $error("interrupt on polled ring");
  a_irq_due: assert property (doneValid && op_q == rxbc_pkg::RXBC_OP_CLOSE
    && ring_q == rxbc_pkg::IRQ_RING |-> irq_q || compIrq)
    else $error("interrupt ring posting without pulse");
  a_ready_back: assert property (doneValid |=> cmdReady && !doneValid)
    else $error("command port not ready after done");
  a_busy_hold: assert property (cmdValid && cmdReady |=> !cmdReady)
    else $error("command port ready while busy");
  // Main scenarios reached
  c_irq: cover property (compIrq);
  c_starve: cover property (doneValid && doneStarve);
  c_mwrite: cover property (memAck && memReq.write);
endmodule
bind rxbc_engine rxbc_engine_properties chk_u (.*);
`default_nettype wire

/* File: dv/rxbc_mem_model.sv */
// Host memory model answering the engine's master requests
`timescale 1ns/1ps
`default_nettype none
module rxbc_mem_model (
  input  wire logic                clk_sys,
  input  wire logic                nrst,
  input  wire rxbc_pkg::rxbc_mem_s memReq,
  input  wire logic [1:0]          lat,
  output logic                     memAck,
  output logic [31:0]              memRdata
);
  logic [31:0] mem [512];
  logic [1:0]  wait_q;
  // Answer after lat idle cycles; data toggles while idle
  always @(posedge clk_sys) begin
    if (!nrst) begin
      memAck <= 1'b0;
      wait_q <= 2'h0;
      memRdata <= 32'h00000000;
    end else begin
      memAck <= 1'b0;
      memRdata <= ~memRdata;
      if (memReq.valid && !memAck) begin
        if (wait_q == lat) begin
          memAck <= 1'b1;
          wait_q <= 2'h0;
          if (memReq.write)
            mem[memReq.addr[10:2]] <= memReq.wdata;
          else
            memRdata <= mem[memReq.addr[10:2]];
        end else
          wait_q <= wait_q + 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: rtl/rxbc_engine.sv */
// Receive buffer chain and completion engine with Avalon-MM registers
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Take a free buffer only when entry bit 31 is set.
// - Entry read with bit 31 clear means buffer starvation for the channel.
// - Ring mode writes the acquired entry back with bit 31 cleared.
// - FIFO mode only reads the entry, never writes it.
// - Entry bits 29-0 hold address bits 31-2; buffers aligned to bus width.
// - Four-word descriptor heads each buffer; non-last buffers hold N x 48 bytes.
// - Descriptor word 1 bit 31 marks the packet's first buffer.
// - Descriptor word 1 bit 30 marks the packet's final buffer.
// - Descriptor word 1 bits 29-0 link next buffer, zero when last.
// - Descriptor word 2 holds the first four cell header bytes.
// - Descriptor words 0 and 3 are never written.
// - Two completion rings; ring 0 posting raises interrupt, ring 1 is polled.
// - Each ring holds 1 to 1024 entries of eight words.
// - Completion word 0 is last header, or VPI/VCI with low nibble zero.
// - AAL5 overflow bit 31 when cell count passes 1366 without end.
// - AAL5 CRC error bit 30 when computed and trailer CRC differ.
// - Bit 29 set when reassembly ended by buffer starvation.
// - Bit 28 set on reassembly aging time-out.
// - AAL5 abort bit 27 when trailer length is zero.
// - Bit 26 set when the channel carries AAL5.
// - Bits 9-0 carry the congestion cell count.
// - Completion word 2 bit 31 set unless first buffer was never obtained; code clears it only on starvation before a first buffer.
module rxbc_engine (
  input  wire logic               clk_sys,
  input  wire logic               nrst,
  input  wire logic [5:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  input  wire logic [3:0]         avs_byteenable,
  output logic [31:0]             avs_readdata,
  output logic                    avs_waitrequest,
  input  wire logic               cmdValid,
  input  wire rxbc_pkg::rxbc_cmd_s cmdIn,
  output logic                    cmdReady,
  output logic                    doneValid,
  output logic                    doneStarve,
  output rxbc_pkg::rxbc_mem_s     memReq,
  input  wire logic               memAck,
  input  wire logic [31:0]        memRdata,
  output logic                    compIrq
);

  // Whole module state
  typedef struct packed {
    rxbc_pkg::rxbc_state_e st;
    logic [1:0]            ctrl;
    logic [31:0]           freeBase;
    logic [9:0]            freeSize;
    logic [9:0]            freeIdx;
    logic [1:0][31:0]      cqBase;
    logic [1:0][9:0]       cqSize;
    logic [1:0][9:0]       cqIdx;
    rxbc_pkg::rxbc_cmd_s   cmd;
    logic [31:0]           entry;
    logic [29:0]           curBuf;
    logic                  curValid;
    logic                  curFirst;
    logic [29:0]           sopPtr;
    logic                  sopValid;
    logic                  starve;
    logic                  alignErr;
    logic [2:0]            word;
    rxbc_pkg::rxbc_mem_s   mem;
    logic                  cmdReady;
    logic                  doneValid;
    logic                  doneStarve;
    logic                  compIrq;
    logic                  avWait;
    logic [31:0]           avRdata;
  } rxbc_state_s;

  rxbc_state_s q;
  rxbc_state_s d;

  // Build one master request
  function automatic rxbc_pkg::rxbc_mem_s mkReq(input logic wr, input logic [31:0] a,
                                               input logic [31:0] wd);
    rxbc_pkg::rxbc_mem_s r;
    r.valid = 1'b1;
    r.write = wr;
    r.addr  = a;
    r.wdata = wd;
    return r;
  endfunction

  // Merge written bytes under byte enables
  function automatic logic [31:0] beMerge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Byte address of a 30-bit buffer pointer
  function automatic logic [31:0] ptrAddr(input logic [29:0] p);
    return {p, 2'b00};
  endfunction

  // Contents of completion entry word k
  function automatic logic [31:0] compWord(input logic [2:0] k, input rxbc_state_s s);
    logic [31:0] w;
    logic        ovf;
    logic        crc;
    logic        abrt;
    w    = 32'h00000000;
    ovf  = s.cmd.aal5 && !s.cmd.cellEnd && (s.cmd.cellCount > rxbc_pkg::MAX_CELLS);
    crc  = s.cmd.aal5 && (s.cmd.crcCalc != s.cmd.crcTrail);
    abrt = s.cmd.aal5 && (s.cmd.trailer[15:0] == 16'h0000);
    case (k)
      3'h0: begin
        // Header, or VPI/VCI after aging time-out
        w = s.cmd.timeout ? {s.cmd.vpiVci, 4'h0} : s.cmd.header;
      end
      3'h1: begin
        w[rxbc_pkg::CW1_OVF]    = ovf;
        w[rxbc_pkg::CW1_CRC]    = crc;
        w[rxbc_pkg::CW1_STARVE] = s.starve;
        w[rxbc_pkg::CW1_TMO]    = s.cmd.timeout;
        w[rxbc_pkg::CW1_ABORT]  = abrt;
        w[rxbc_pkg::CW1_AAL5]   = s.cmd.aal5;
        w[9:0]                  = s.cmd.efciCount;
      end
      3'h2: begin
        w = {s.sopValid, 1'b0, s.sopPtr};
      end
      3'h3: begin
        w = s.cmd.aal5 ? s.cmd.trailer : 32'h00000000;
      end
      3'h4: begin
        // Ownership handed back to host, error summary set
        w = {1'b0, (ovf || crc || s.starve || s.cmd.timeout || abrt), s.cmd.fifoIndex};
      end
      default: begin
        w = 32'h00000000;
      end
    endcase
    return w;
  endfunction

  // Next-state logic
  always_comb begin
    logic [31:0] rd;
    logic [31:0] freeAddr;
    logic [31:0] cqAddr;
    logic        rs;
    rd       = 32'h00000000;
    d        = q;
    d.doneValid = 1'b0;
    d.compIrq   = 1'b0;
    d.avWait    = 1'b1;
    rs       = q.cmd.ringSel;
    // Ring mode indexes the ring, FIFO mode reads one fixed word
    freeAddr = q.ctrl[rxbc_pkg::CTRL_FIFO_BIT] ? q.freeBase
             : q.freeBase + {20'h00000, q.freeIdx, 2'b00};
    cqAddr   = q.cqBase[rs] + {17'h00000, q.cqIdx[rs], 5'h00} + {27'h0000000, q.word, 2'b00};

    // Register read mux
    case (avs_address)
      rxbc_pkg::REG_CTRL:      rd = {30'h00000000, q.ctrl};
      rxbc_pkg::REG_FREE_BASE: rd = q.freeBase;
      rxbc_pkg::REG_FREE_SIZE: rd = {22'h000000, q.freeSize};
      rxbc_pkg::REG_CQ0_BASE:  rd = q.cqBase[0];
      rxbc_pkg::REG_CQ0_SIZE:  rd = {22'h000000, q.cqSize[0]};
      rxbc_pkg::REG_CQ1_BASE:  rd = q.cqBase[1];
      rxbc_pkg::REG_CQ1_SIZE:  rd = {22'h000000, q.cqSize[1]};
      rxbc_pkg::REG_STATUS: begin
        rd[rxbc_pkg::STAT_BUSY_BIT]   = (q.st != rxbc_pkg::RXBC_IDLE);
        rd[rxbc_pkg::STAT_STARVE_BIT] = q.starve;
        rd[rxbc_pkg::STAT_ALIGN_BIT]  = q.alignErr;
        rd[rxbc_pkg::STAT_FIDX_LSB +: 10] = q.freeIdx;
      end
      rxbc_pkg::REG_CQ_IDX: begin
        rd[9:0]                          = q.cqIdx[0];
        rd[rxbc_pkg::CQ1_IDX_LSB +: 10]  = q.cqIdx[1];
      end
      default: rd = 32'h00000000;
    endcase

    // Avalon slave: one wait cycle, then the access completes
    if ((avs_read || avs_write) && q.avWait) begin
      d.avWait = 1'b0;
      if (avs_read) begin
        d.avRdata = rd;
      end
    end
    if (avs_write && !q.avWait) begin
      case (avs_address)
        rxbc_pkg::REG_CTRL: begin
          d.ctrl = 2'(beMerge({30'h00000000, q.ctrl}, avs_writedata, avs_byteenable));
        end
        rxbc_pkg::REG_FREE_BASE: d.freeBase = beMerge(q.freeBase, avs_writedata, avs_byteenable);
        rxbc_pkg::REG_FREE_SIZE: begin
          d.freeSize = 10'(beMerge({22'h000000, q.freeSize}, avs_writedata, avs_byteenable));
          d.freeIdx  = 10'h000;
        end
        rxbc_pkg::REG_CQ0_BASE: d.cqBase[0] = beMerge(q.cqBase[0], avs_writedata, avs_byteenable);
        rxbc_pkg::REG_CQ0_SIZE: begin
          d.cqSize[0] = 10'(beMerge({22'h000000, q.cqSize[0]}, avs_writedata, avs_byteenable));
          d.cqIdx[0]  = 10'h000;
        end
        rxbc_pkg::REG_CQ1_BASE: d.cqBase[1] = beMerge(q.cqBase[1], avs_writedata, avs_byteenable);
        rxbc_pkg::REG_CQ1_SIZE: begin
          d.cqSize[1] = 10'(beMerge({22'h000000, q.cqSize[1]}, avs_writedata, avs_byteenable));
          d.cqIdx[1]  = 10'h000;
        end
        rxbc_pkg::REG_STATUS: begin
          // Write one to clear the sticky alignment error
          if (avs_byteenable[3] && avs_writedata[rxbc_pkg::STAT_ALIGN_BIT]) begin
            d.alignErr = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Buffer chain and completion sequencer
    case (q.st)
      rxbc_pkg::RXBC_IDLE: begin
        d.cmdReady = 1'b1;
        if (cmdValid && q.cmdReady) begin
          d.cmdReady = 1'b0;
          d.cmd      = cmdIn;
          d.word     = 3'h0;
          if (cmdIn.op == rxbc_pkg::RXBC_OP_NEWBUF) begin
            d.st = rxbc_pkg::RXBC_FETCH;
          end else begin
            d.st = q.curValid ? rxbc_pkg::RXBC_END1 : rxbc_pkg::RXBC_POST;
          end
        end
      end
      rxbc_pkg::RXBC_FETCH: begin
        // Read the free-buffer entry
        if (!q.mem.valid) begin
          d.mem = mkReq(1'b0, freeAddr, 32'h00000000);
        end else if (memAck) begin
          d.mem.valid = 1'b0;
          d.entry     = memRdata;
          d.st        = rxbc_pkg::RXBC_CHECK;
        end
      end
      rxbc_pkg::RXBC_CHECK: begin
        if (!q.entry[rxbc_pkg::ENT_OWN_BIT]) begin
          // Starvation: no buffer, first-buffer pointer invalid if none yet
          d.starve     = 1'b1;
          d.doneStarve = 1'b1;
          if (!q.curValid) begin
            d.sopValid = 1'b0;
          end
          d.st = rxbc_pkg::RXBC_DONE;
        end else begin
          if (q.ctrl[rxbc_pkg::CTRL_BUS64_BIT] && q.entry[0]) begin
            d.alignErr = 1'b1;
          end
          // FIFO mode skips the write-back
          if (q.ctrl[rxbc_pkg::CTRL_FIFO_BIT]) begin
            d.st = q.curValid ? rxbc_pkg::RXBC_LINK1 : rxbc_pkg::RXBC_TAKE;
          end else begin
            d.st = rxbc_pkg::RXBC_RETURN;
          end
        end
      end
      rxbc_pkg::RXBC_RETURN: begin
        // Hand the ring slot back with ownership cleared
        if (!q.mem.valid) begin
          d.mem = mkReq(1'b1, freeAddr, {1'b0, q.entry[30:0]});
        end else if (memAck) begin
          d.mem.valid = 1'b0;
          d.freeIdx   = (q.freeIdx == q.freeSize) ? 10'h000 : q.freeIdx + 10'h001;
          d.st        = q.curValid ? rxbc_pkg::RXBC_LINK1 : rxbc_pkg::RXBC_TAKE;
        end
      end
      rxbc_pkg::RXBC_LINK1: begin
        // Link the full buffer to the new one
        if (!q.mem.valid) begin
          d.mem = mkReq(1'b1, ptrAddr(q.curBuf) + rxbc_pkg::DSC_W1_OFS,
                        {q.curFirst, 1'b0, q.entry[29:0]});
        end else if (memAck) begin
          d.mem.valid = 1'b0;
          d.st        = rxbc_pkg::RXBC_LINK2;
        end
      end
      rxbc_pkg::RXBC_LINK2: begin
        if (!q.mem.valid) begin
          d.mem = mkReq(1'b1, ptrAddr(q.curBuf) + rxbc_pkg::DSC_W2_OFS, q.cmd.header);
        end else if (memAck) begin
          d.mem.valid = 1'b0;
          d.st        = rxbc_pkg::RXBC_TAKE;
        end
      end
      rxbc_pkg::RXBC_TAKE: begin
        // New buffer becomes current
        d.curBuf     = q.entry[29:0];
        d.curValid   = 1'b1;
        d.curFirst   = !q.curValid;
        d.doneStarve = 1'b0;
        if (!q.curValid) begin
          d.sopPtr   = q.entry[29:0];
          d.sopValid = !q.starve;
        end
        d.st = rxbc_pkg::RXBC_DONE;
      end
      rxbc_pkg::RXBC_END1: begin
        // Close the last buffer: end mark, null link
        if (!q.mem.valid) begin
          d.mem = mkReq(1'b1, ptrAddr(q.curBuf) + rxbc_pkg::DSC_W1_OFS,
                        {q.curFirst, 1'b1, 30'h00000000});
        end else if (memAck) begin
          d.mem.valid = 1'b0;
          d.st        = rxbc_pkg::RXBC_END2;
        end
      end
      rxbc_pkg::RXBC_END2: begin
        if (!q.mem.valid) begin
          d.mem = mkReq(1'b1, ptrAddr(q.curBuf) + rxbc_pkg::DSC_W2_OFS, q.cmd.header);
        end else if (memAck) begin
          d.mem.valid = 1'b0;
          d.st        = rxbc_pkg::RXBC_POST;
        end
      end
      rxbc_pkg::RXBC_POST: begin
        // Eight-word completion entry into the selected ring
        if (!q.mem.valid) begin
          d.mem = mkReq(1'b1, cqAddr, compWord(q.word, q));
        end else if (memAck) begin
          d.mem.valid = 1'b0;
          if (q.word == rxbc_pkg::COMP_LAST) begin
            d.cqIdx[rs]  = (q.cqIdx[rs] == q.cqSize[rs]) ? 10'h000 : q.cqIdx[rs] + 10'h001;
            d.compIrq    = (rs == rxbc_pkg::IRQ_RING);
            d.doneStarve = q.starve;
            d.curValid   = 1'b0;
            d.curFirst   = 1'b0;
            d.starve     = 1'b0;
            d.sopValid   = 1'b1;
            d.st         = rxbc_pkg::RXBC_DONE;
          end else begin
            d.word = q.word + 3'h1;
          end
        end
      end
      rxbc_pkg::RXBC_DONE: begin
        d.doneValid = 1'b1;
        d.st        = rxbc_pkg::RXBC_IDLE;
      end
      default: begin
        d.st = rxbc_pkg::RXBC_IDLE;
      end
    endcase
  end

  // State register with synchronous reset
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      q          <= '0;
      q.st       <= rxbc_pkg::RXBC_IDLE;
      q.ctrl     <= rxbc_pkg::CTRL_RST;
      q.freeBase <= rxbc_pkg::BASE_RST;
      q.freeSize <= rxbc_pkg::SIZE_RST;
      q.sopValid <= 1'b1;
      q.avWait   <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from state flops
  assign avs_readdata    = q.avRdata;
  assign avs_waitrequest = q.avWait;
  assign cmdReady        = q.cmdReady;
  assign doneValid       = q.doneValid;
  assign doneStarve      = q.doneStarve;
  assign memReq          = q.mem;
  assign compIrq         = q.compIrq;

endmodule

`default_nettype wire

/* File: rtl/rxbc_pkg.sv */
// Package for the receive buffer chain and completion engine
package rxbc_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [5:0] REG_CTRL      = 6'h00;
  localparam logic [5:0] REG_FREE_BASE = 6'h04;
  localparam logic [5:0] REG_FREE_SIZE = 6'h08;
  localparam logic [5:0] REG_CQ0_BASE  = 6'h0C;
  localparam logic [5:0] REG_CQ0_SIZE  = 6'h10;
  localparam logic [5:0] REG_CQ1_BASE  = 6'h14;
  localparam logic [5:0] REG_CQ1_SIZE  = 6'h18;
  localparam logic [5:0] REG_STATUS    = 6'h1C;
  localparam logic [5:0] REG_CQ_IDX    = 6'h20;

  // Control register fields and reset values
  localparam int         CTRL_FIFO_BIT  = 0;
  localparam int         CTRL_BUS64_BIT = 1;
  localparam logic [1:0] CTRL_RST       = 2'h0;
  localparam logic [9:0] SIZE_RST       = 10'h000;
  localparam logic [31:0] BASE_RST      = 32'h00000000;

  // Status and completion index register fields
  localparam int STAT_BUSY_BIT   = 31;
  localparam int STAT_STARVE_BIT = 30;
  localparam int STAT_ALIGN_BIT  = 29;
  localparam int STAT_FIDX_LSB   = 0;
  localparam int CQ1_IDX_LSB     = 16;

  // Free-buffer entry layout
  localparam int ENT_OWN_BIT = 31;
  localparam int ADDR_W      = 30;

  // Data buffer descriptor layout
  localparam logic [31:0] DSC_W1_OFS = 32'h00000004;
  localparam logic [31:0] DSC_W2_OFS = 32'h00000008;
  localparam int          DSC_SOP    = 31;
  localparam int          DSC_EOP    = 30;

  // Completion entry layout
  localparam int          COMP_WORDS  = 8;
  localparam int          COMP_SHIFT  = 5;
  localparam logic [2:0]  COMP_LAST   = 3'h7;
  localparam int          CW1_OVF     = 31;
  localparam int          CW1_CRC     = 30;
  localparam int          CW1_STARVE  = 29;
  localparam int          CW1_TMO     = 28;
  localparam int          CW1_ABORT   = 27;
  localparam int          CW1_AAL5    = 26;
  localparam logic [10:0] MAX_CELLS   = 11'h556;

  // Completion ring that raises the interrupt
  localparam logic        IRQ_RING    = 1'b0;

  typedef enum logic [0:0] {
    RXBC_OP_NEWBUF = 1'b0,
    RXBC_OP_CLOSE  = 1'b1
  } rxbc_op_e;

  typedef enum logic [3:0] {
    RXBC_IDLE   = 4'h0,
    RXBC_FETCH  = 4'h1,
    RXBC_CHECK  = 4'h2,
    RXBC_RETURN = 4'h3,
    RXBC_LINK1  = 4'h4,
    RXBC_LINK2  = 4'h5,
    RXBC_TAKE   = 4'h6,
    RXBC_END1   = 4'h7,
    RXBC_END2   = 4'h8,
    RXBC_POST   = 4'h9,
    RXBC_DONE   = 4'hA
  } rxbc_state_e;

  // Command from the reassembly core
  typedef struct packed {
    rxbc_op_e    op;
    logic        ringSel;
    logic [31:0] header;
    logic [27:0] vpiVci;
    logic        timeout;
    logic        aal5;
    logic [10:0] cellCount;
    logic        cellEnd;
    logic [31:0] crcCalc;
    logic [31:0] crcTrail;
    logic [31:0] trailer;
    logic [9:0]  efciCount;
    logic [29:0] fifoIndex;
  } rxbc_cmd_s;

  // Host memory master request
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } rxbc_mem_s;

endpackage
